// [magnetic_cfg.svh]
`ifndef MAGNETIC_CFG_SVH
`define MAGNETIC_CFG_SVH
// How it works
// - channel 4 positive, channel 5 negative field
// - both channels combine into differential field data
// - proximity and touch thresholds drive two outputs
// - global events bit 2 toggles when the proximity or touch output changes
// - flags: polarity, proximity, touch; rest zero
// - polarity flag shows north or south field
// - 16-bit amplitude, low byte first address
// - optional inverse calculation linearizes amplitude output
// - settings 0 hold divider and tuning mode

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define ADDR_GLOBAL_EVENT_SUMMARY 8'h11
`define ADDR_MAGNETIC_UI_FLAGS 8'h16
`define ADDR_MAGNETIC_AMPLITUDE_LOW 8'h17
`define ADDR_MAGNETIC_AMPLITUDE_HIGH 8'h18
`define ADDR_MAGNETIC_CHARGE_TUNING_CFG 8'h90
`define ADDR_MAGNETIC_TUNING_BASE_TARGET 8'h91
`define ADDR_SWITCH_UI_CFG 8'hA0
`define ADDR_SWITCH_UI_PROX_THRESHOLD 8'hA1
`define ADDR_SWITCH_UI_TOUCH_THRESHOLD 8'hA2

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define EVENT_MAGNETIC_BIT 2
`define FLAG_POLARITY_BIT 0
`define FLAG_PROX_BIT 1
`define FLAG_TOUCH_BIT 2
`define CHARGE_DIVIDER_MSB 3
`define CHARGE_DIVIDER_LSB 0
`define TUNING_MODE_MSB 5
`define TUNING_MODE_LSB 4
`define TUNING_BASE_MSB 3
`define TUNING_BASE_LSB 0
`define TUNING_TARGET_MSB 7
`define TUNING_TARGET_LSB 4
`define SWITCH_INVERSE_BIT 0
`define SWITCH_ENABLE_BIT 1

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define RESET_CHARGE_TUNING_CFG 8'h34
`define RESET_TUNING_BASE_TARGET 8'h80
`define RESET_SWITCH_UI_CFG 8'h02
`define RESET_PROX_THRESHOLD 8'h10
`define RESET_TOUCH_THRESHOLD 8'h20

// ----------------------------------------------------------------
// timing and arithmetic
// ----------------------------------------------------------------
// idle time between conversions is (divider + 1) * 16 clocks
`define RATE_FILL 4'hF
`define INV_NUMERATOR 32'h00FFFFFF
`define AMPLITUDE_SATURATED 16'hFFFF
`endif

// [magnetic_pkg.sv]
package magnetic_pkg;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_START_POS = 3'b001,
    ST_WAIT_POS = 3'b010,
    ST_START_NEG = 3'b011,
    ST_WAIT_NEG = 3'b100,
    ST_COMBINE = 3'b101
  } seq_state_type;

  typedef logic [15:0] amplitude_type;
endpackage

// [conv_if.sv]
`timescale 1ns/1ps
interface conv_if #(parameter int WIDTH = 16);
  logic start;
  logic done;
  logic [WIDTH-1:0] value;
  modport capture(input start, output done, output value);
  modport sequencer(output start, input done, input value);
endinterface

// [field_channel_capture.sv]
`timescale 1ns/1ps
module field_channel_capture #(
  parameter int WIDTH = 16
) (
  input wire logic clock,
  input wire logic sys_rst,
  conv_if.capture link,
  output logic raw_start,
  input wire logic raw_valid,
  input wire logic [WIDTH-1:0] raw_result
);
  logic busy;

  assign raw_start = link.start;

  // a stray result outside a requested conversion is dropped
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      busy <= 1'b0;
    end else if (link.start) begin
      busy <= 1'b1;
    end else if (raw_valid) begin
      busy <= 1'b0;
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      link.value <= '0;
    end else if (busy && raw_valid) begin
      link.value <= raw_result;
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      link.done <= 1'b0;
    end else begin
      link.done <= busy && raw_valid && !link.start;
    end
  end
endmodule

// [hall_effect_sensor_readout.sv]
`timescale 1ns/1ps
`include "magnetic_cfg.svh"
module hall_effect_sensor_readout #(
  parameter int WIDTH = 16
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd,
  output logic [7:0] reg_rd_data,
  output logic pos_start,
  input wire logic pos_valid,
  input wire logic [WIDTH-1:0] pos_result,
  output logic neg_start,
  input wire logic neg_valid,
  input wire logic [WIDTH-1:0] neg_result,
  output logic magnetic_prox_out,
  output logic magnetic_touch_out,
  output logic magnetic_polarity,
  output logic [1:0] auto_tuning_mode,
  output logic [3:0] auto_tuning_base,
  output logic [3:0] auto_tuning_target
);
  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  logic [7:0] charge_tuning_cfg;
  logic [7:0] tuning_base_target;
  logic [7:0] switch_cfg;
  logic [7:0] prox_threshold;
  logic [7:0] touch_threshold;

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      charge_tuning_cfg <= `RESET_CHARGE_TUNING_CFG;
      tuning_base_target <= `RESET_TUNING_BASE_TARGET;
      switch_cfg <= `RESET_SWITCH_UI_CFG;
      prox_threshold <= `RESET_PROX_THRESHOLD;
      touch_threshold <= `RESET_TOUCH_THRESHOLD;
    end else if (reg_wr) begin
      case (reg_addr)
        `ADDR_MAGNETIC_CHARGE_TUNING_CFG: charge_tuning_cfg <= reg_wdata;
        `ADDR_MAGNETIC_TUNING_BASE_TARGET: tuning_base_target <= reg_wdata;
        `ADDR_SWITCH_UI_CFG: switch_cfg <= reg_wdata;
        `ADDR_SWITCH_UI_PROX_THRESHOLD: prox_threshold <= reg_wdata;
        `ADDR_SWITCH_UI_TOUCH_THRESHOLD: touch_threshold <= reg_wdata;
        default: begin
        end
      endcase
    end
  end

  // tuning itself lives in the front end; it only sees these fields
  assign auto_tuning_mode = charge_tuning_cfg[`TUNING_MODE_MSB:`TUNING_MODE_LSB];
  assign auto_tuning_base = tuning_base_target[`TUNING_BASE_MSB:`TUNING_BASE_LSB];
  assign auto_tuning_target = tuning_base_target[`TUNING_TARGET_MSB:`TUNING_TARGET_LSB];

  // ----------------------------------------------------------------
  // channel capture
  // ----------------------------------------------------------------
  conv_if #(.WIDTH(WIDTH)) pos_link();
  conv_if #(.WIDTH(WIDTH)) neg_link();

  field_channel_capture #(.WIDTH(WIDTH)) pos_capture (
    .clock(clock),
    .sys_rst(sys_rst),
    .link(pos_link),
    .raw_start(pos_start),
    .raw_valid(pos_valid),
    .raw_result(pos_result)
  );

  field_channel_capture #(.WIDTH(WIDTH)) neg_capture (
    .clock(clock),
    .sys_rst(sys_rst),
    .link(neg_link),
    .raw_start(neg_start),
    .raw_valid(neg_valid),
    .raw_result(neg_result)
  );

  // ----------------------------------------------------------------
  // conversion sequencer
  // ----------------------------------------------------------------
  magnetic_pkg::seq_state_type state;
  magnetic_pkg::seq_state_type next_state;
  logic [11:0] rate_count;
  logic [11:0] rate_limit;

  assign rate_limit = {4'h0, charge_tuning_cfg[`CHARGE_DIVIDER_MSB:`CHARGE_DIVIDER_LSB],
                       `RATE_FILL};

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      rate_count <= 12'h000;
    end else if (state != magnetic_pkg::ST_IDLE) begin
      rate_count <= 12'h000;
    end else begin
      rate_count <= rate_count + 12'h001;
    end
  end

  // positive channel always converts first, then negative
  always_comb begin
    next_state = state;
    case (state)
      magnetic_pkg::ST_IDLE: begin
        if (rate_count >= rate_limit) begin
          next_state = magnetic_pkg::ST_START_POS;
        end
      end
      magnetic_pkg::ST_START_POS: next_state = magnetic_pkg::ST_WAIT_POS;
      magnetic_pkg::ST_WAIT_POS: begin
        if (pos_link.done) begin
          next_state = magnetic_pkg::ST_START_NEG;
        end
      end
      magnetic_pkg::ST_START_NEG: next_state = magnetic_pkg::ST_WAIT_NEG;
      magnetic_pkg::ST_WAIT_NEG: begin
        if (neg_link.done) begin
          next_state = magnetic_pkg::ST_COMBINE;
        end
      end
      magnetic_pkg::ST_COMBINE: next_state = magnetic_pkg::ST_IDLE;
      default: next_state = magnetic_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      state <= magnetic_pkg::ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  assign pos_link.start = (state == magnetic_pkg::ST_START_POS);
  assign neg_link.start = (state == magnetic_pkg::ST_START_NEG);

  // ----------------------------------------------------------------
  // differential processing
  // ----------------------------------------------------------------
  logic [WIDTH:0] field_diff;
  logic [WIDTH:0] field_mag_wide;
  magnetic_pkg::amplitude_type field_mag;
  logic [31:0] inverse_quot;
  magnetic_pkg::amplitude_type inverse_amp;
  magnetic_pkg::amplitude_type report_amp;
  logic field_south;
  logic ui_enable;
  logic prox_hit;
  logic touch_hit;

  // common-mode cancels in the subtraction
  assign field_diff = {1'b0, pos_link.value} - {1'b0, neg_link.value};
  assign field_south = field_diff[WIDTH];
  assign field_mag_wide = field_south ? (~field_diff + 1'b1) : field_diff;
  assign field_mag = field_mag_wide[15:0];

  // a full divider is costly; it is combinational and its quotient is registered only in ST_COMBINE
  assign inverse_quot = (field_mag == 16'h0000) ? `INV_NUMERATOR
                        : (`INV_NUMERATOR / {16'h0000, field_mag});
  assign inverse_amp = (inverse_quot[31:16] != 16'h0000) ? `AMPLITUDE_SATURATED
                       : inverse_quot[15:0];
  assign report_amp = switch_cfg[`SWITCH_INVERSE_BIT] ? inverse_amp : field_mag;

  // thresholds act on the raw magnitude so linearizing never flips them
  assign ui_enable = switch_cfg[`SWITCH_ENABLE_BIT];
  assign prox_hit = ui_enable && (field_mag >= {4'h0, prox_threshold, 4'h0});
  assign touch_hit = ui_enable && (field_mag >= {4'h0, touch_threshold, 4'h0});

  // ----------------------------------------------------------------
  // result registers
  // ----------------------------------------------------------------
  magnetic_pkg::amplitude_type amplitude;
  logic event_toggle;
  logic combine_now;

  assign combine_now = (state == magnetic_pkg::ST_COMBINE);

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      magnetic_polarity <= 1'b0;
      magnetic_prox_out <= 1'b0;
      magnetic_touch_out <= 1'b0;
      amplitude <= 16'h0000;
    end else if (combine_now) begin
      magnetic_polarity <= field_south;
      magnetic_prox_out <= prox_hit;
      magnetic_touch_out <= touch_hit;
      amplitude <= report_amp;
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      event_toggle <= 1'b0;
    end else if (combine_now && ((prox_hit != magnetic_prox_out)
                                 || (touch_hit != magnetic_touch_out))) begin
      event_toggle <= ~event_toggle;
    end
  end

  // ----------------------------------------------------------------
  // register read port
  // ----------------------------------------------------------------
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rd_data <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        `ADDR_GLOBAL_EVENT_SUMMARY: begin
          reg_rd_data <= {5'h00, event_toggle, 2'h0};
        end
        `ADDR_MAGNETIC_UI_FLAGS: begin
          reg_rd_data <= {5'h00, magnetic_touch_out, magnetic_prox_out,
                          magnetic_polarity};
        end
        `ADDR_MAGNETIC_AMPLITUDE_LOW: reg_rd_data <= amplitude[7:0];
        `ADDR_MAGNETIC_AMPLITUDE_HIGH: reg_rd_data <= amplitude[15:8];
        `ADDR_MAGNETIC_CHARGE_TUNING_CFG: reg_rd_data <= charge_tuning_cfg;
        `ADDR_MAGNETIC_TUNING_BASE_TARGET: reg_rd_data <= tuning_base_target;
        `ADDR_SWITCH_UI_CFG: reg_rd_data <= switch_cfg;
        `ADDR_SWITCH_UI_PROX_THRESHOLD: reg_rd_data <= prox_threshold;
        `ADDR_SWITCH_UI_TOUCH_THRESHOLD: reg_rd_data <= touch_threshold;
        default: reg_rd_data <= 8'h00;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_neg_after_pos;
    @(posedge clock) disable iff (sys_rst)
    $rose(neg_start) |-> $past(state) == magnetic_pkg::ST_WAIT_POS && $past(pos_link.done);
  endproperty
  a_neg_after_pos: assert property (p_neg_after_pos)
    else $error("negative channel started before positive finished");

  property p_diff_magnitude;
    @(posedge clock) disable iff (sys_rst)
    combine_now && !switch_cfg[`SWITCH_INVERSE_BIT] |=>
      amplitude == (($past(pos_link.value) >= $past(neg_link.value)) ?
        $past(pos_link.value) - $past(neg_link.value) :
        $past(neg_link.value) - $past(pos_link.value));
  endproperty
  a_diff_magnitude: assert property (p_diff_magnitude)
    else $error("amplitude differs from channel difference");

  property p_touch_level;
    @(posedge clock) disable iff (sys_rst)
    combine_now && ui_enable && field_mag >= {4'h0, touch_threshold, 4'h0}
      |=> magnetic_touch_out;
  endproperty
  a_touch_level: assert property (p_touch_level)
    else $error("touch output missing above touch level");

  property p_prox_level;
    @(posedge clock) disable iff (sys_rst)
    combine_now && field_mag < {4'h0, prox_threshold, 4'h0} |=> !magnetic_prox_out;
  endproperty
  a_prox_level: assert property (p_prox_level)
    else $error("proximity output set below proximity level");

  property p_event_cause;
    @(posedge clock) disable iff (sys_rst)
    $changed(event_toggle) |-> $past(combine_now) &&
      ($changed(magnetic_prox_out) || $changed(magnetic_touch_out));
  endproperty
  a_event_cause: assert property (p_event_cause)
    else $error("event bit toggled without a detection change");

  property p_flags_read;
    @(posedge clock) disable iff (sys_rst)
    reg_rd && reg_addr == `ADDR_MAGNETIC_UI_FLAGS ##1 $stable(magnetic_prox_out) |->
      reg_rd_data[7:3] == 5'h00 && reg_rd_data[`FLAG_PROX_BIT] == magnetic_prox_out;
  endproperty
  a_flags_read: assert property (p_flags_read)
    else $error("flags read back wrong");

  property p_polarity;
    @(posedge clock) disable iff (sys_rst)
    combine_now ##1 1'b1 |-> magnetic_polarity == $past(neg_link.value > pos_link.value);
  endproperty
  a_polarity: assert property (p_polarity)
    else $error("polarity does not follow field sign");

  property p_amplitude_high_read;
    @(posedge clock) disable iff (sys_rst)
    reg_rd && reg_addr == `ADDR_MAGNETIC_AMPLITUDE_HIGH && !combine_now
      |=> reg_rd_data == amplitude[15:8];
  endproperty
  a_amplitude_high_read: assert property (p_amplitude_high_read)
    else $error("high amplitude byte read back wrong");

  property p_same_measurement;
    @(posedge clock) disable iff (sys_rst)
    ($changed(amplitude) || $changed(magnetic_polarity)) |-> $past(combine_now);
  endproperty
  a_same_measurement: assert property (p_same_measurement)
    else $error("result register changed outside a combine step");
endmodule

// [field_channel_model.sv]
`timescale 1ns/1ps
module field_channel_model #(
  parameter int LATENCY = 3
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic start,
  input wire logic [15:0] level,
  output logic valid,
  output logic [15:0] result
);
  int count;
  logic busy;
  logic [15:0] held;
  // ----------------------------------------
  // conversion engine stand-in
  // ----------------------------------------
  // result flips while not valid so a stale sample can never look right
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      busy <= 1'b0;
      count <= 0;
      valid <= 1'b0;
      held <= 16'h0000;
      result <= 16'h0000;
    end else begin
      valid <= 1'b0;
      result <= ~result;
      if (start) begin
        busy <= 1'b1;
        count <= LATENCY;
        held <= level;
      end else if (busy) begin
        count <= count - 1;
        if (count == 1) begin
          busy <= 1'b0;
          valid <= 1'b1;
          result <= held;
        end
      end
    end
  end
endmodule

// [tb.sv]
`timescale 1ns/1ps
module tb;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic reg_wr = 1'b0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rd_data;
  logic pos_start, pos_valid, neg_start, neg_valid;
  logic [15:0] pos_result, neg_result;
  logic [15:0] pos_level = 16'h0000;
  logic [15:0] neg_level = 16'h0000;
  logic prox, touch, pol;
  logic [1:0] mode;
  logic [3:0] base, target;
  int mismatches = 0;
  int checks_done = 0;
  logic ev = 1'b0, last_pr = 1'b0, last_tc = 1'b0, inv_on = 1'b0, ui_on = 1'b1;
  logic [7:0] prox_thr = 8'h10, touch_thr = 8'h20;

  always #25 clock = ~clock;

  hall_effect_sensor_readout uut (.clock(clock), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rd_data(reg_rd_data),
    .pos_start(pos_start), .pos_valid(pos_valid), .pos_result(pos_result),
    .neg_start(neg_start), .neg_valid(neg_valid), .neg_result(neg_result),
    .magnetic_prox_out(prox), .magnetic_touch_out(touch), .magnetic_polarity(pol),
    .auto_tuning_mode(mode), .auto_tuning_base(base), .auto_tuning_target(target));
  // fast positive and slow negative channel
  field_channel_model #(.LATENCY(2)) pos_model (.clock(clock), .sys_rst(sys_rst),
    .start(pos_start), .level(pos_level), .valid(pos_valid), .result(pos_result));
  field_channel_model #(.LATENCY(9)) neg_model (.clock(clock), .sys_rst(sys_rst),
    .start(neg_start), .level(neg_level), .valid(neg_valid), .result(neg_result));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR t=%0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clock);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clock);
    reg_wr = 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(negedge clock);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clock);
    reg_rd = 1'b0;
    check(reg_rd_data, exp);
  endtask

  // pulses stand a whole cycle, so falling edges catch them race free
  task automatic wait_high(ref logic sig);
    int n;
    n = 0;
    do begin
      @(negedge clock);
      n++;
    end while (sig !== 1'b1 && n < 500);
    check(sig, 1'b1);
  endtask

  task automatic run_conv(input logic [15:0] p, input logic [15:0] n);
    logic [15:0] mag, amp;
    logic [31:0] q;
    logic pr, tc, po;
    pos_level = p;
    neg_level = n;
    wait_high(pos_start);
    wait_high(neg_valid);
    repeat (3) @(posedge clock);
    @(negedge clock);
    po = n > p;
    mag = po ? n - p : p - n;
    q = (mag == 16'h0000) ? 32'h0000FFFF : 32'h00FFFFFF / mag;
    amp = !inv_on ? mag : (q > 32'h0000FFFF ? 16'hFFFF : q[15:0]);
    pr = ui_on && mag >= {4'h0, prox_thr, 4'h0};
    tc = ui_on && mag >= {4'h0, touch_thr, 4'h0};
    if (pr != last_pr || tc != last_tc)
      ev = ~ev;
    last_pr = pr;
    last_tc = tc;
    check(prox, pr);
    check(touch, tc);
    check(pol, po);
    rd_chk(8'h16, {5'h00, tc, pr, po});
    rd_chk(8'h17, amp[7:0]);
    rd_chk(8'h18, amp[15:8]);
    rd_chk(8'h11, {5'h00, ev, 2'h0});
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic test_registers();
    logic [7:0] a [5] = '{8'h90, 8'h91, 8'hA0, 8'hA1, 8'hA2};
    logic [7:0] r [5] = '{8'h34, 8'h80, 8'h02, 8'h10, 8'h20};
    check({mode, base, target}, {2'b11, 4'h0, 4'h8});
    for (int i = 0; i < 5; i++)
      rd_chk(a[i], r[i]);
    wr(8'h90, 8'h30);
    wr(8'h91, 8'hA5);
    rd_chk(8'h90, 8'h30);
    rd_chk(8'h91, 8'hA5);
    check({mode, base, target}, {2'b11, 4'h5, 4'hA});
    wr(8'h16, 8'hFF);
    rd_chk(8'h16, 8'h00);
    wr(8'h17, 8'hFF);
    rd_chk(8'h17, 8'h00);
    rd_chk(8'h55, 8'h00);
    $display("test_registers done");
  endtask

  task automatic test_levels();
    run_conv(16'h0300, 16'h0080);
    run_conv(16'h0100, 16'h0250);
    run_conv(16'h0200, 16'h0100);
    run_conv(16'h00FF, 16'h0000);
    $display("test_levels done");
  endtask

  task automatic test_inverse();
    wr(8'hA0, 8'h03);
    inv_on = 1'b1;
    run_conv(16'h0005, 16'h0005);
    run_conv(16'h1000, 16'h0000);
    wr(8'hA0, 8'h00);
    inv_on = 1'b0;
    ui_on = 1'b0;
    run_conv(16'h0500, 16'h0000);
    $display("test_inverse done");
  endtask

  task automatic test_thresholds();
    wr(8'hA0, 8'h02);
    ui_on = 1'b1;
    wr(8'hA1, 8'h05);
    wr(8'hA2, 8'h08);
    prox_thr = 8'h05;
    touch_thr = 8'h08;
    run_conv(16'h0060, 16'h0000);
    run_conv(16'h0000, 16'h0080);
    $display("test_thresholds done");
  endtask

  // idle span after a combine must be (divider + 1) * 16 cycles
  task automatic test_rate();
    logic [15:0] gap;
    gap = 16'h0000;
    wr(8'h90, 8'h32);
    wait_high(pos_start);
    wait_high(neg_valid);
    repeat (3) @(posedge clock);
    @(negedge clock);
    do begin
      @(negedge clock);
      gap++;
    end while (pos_start !== 1'b1 && gap < 16'h0100);
    check(gap, 16'h0030);
    $display("test_rate done");
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clock);
    mismatches++;
    $display("ERROR t=%0t watchdog expired", $time);
    report_and_stop();
  end

  initial begin
    repeat (8) @(negedge clock);
    sys_rst = 1'b0;
    test_registers();
    test_levels();
    test_inverse();
    test_thresholds();
    test_rate();
    report_and_stop();
  end
endmodule
